// *** logic/rrit_top.sv ***
// ROM, RAM, two I/O ports and an interval timer behind a byte bus.
// Assumes address, R/W and data come from a processor on SYS_CLK;
// every enabled clock is one bus cycle. Port pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "rrit_consts.svh"

module rrit_top #(
    parameter logic              SEL1_IS_SELECT = 1'b0,
    parameter logic              SEL2_IS_SELECT = 1'b0,
    parameter rrit_pkg::rrit_dec_t ROM_CARE     = `RRIT_ROM_CARE,
    parameter rrit_pkg::rrit_dec_t ROM_MATCH    = `RRIT_ROM_MATCH,
    parameter rrit_pkg::rrit_dec_t RAM_CARE     = `RRIT_RAM_CARE,
    parameter rrit_pkg::rrit_dec_t RAM_MATCH    = `RRIT_RAM_MATCH,
    parameter rrit_pkg::rrit_dec_t IO_CARE      = `RRIT_IO_CARE,
    parameter rrit_pkg::rrit_dec_t IO_MATCH     = `RRIT_IO_MATCH
) (
    input  wire logic                 SYS_CLK,
    input  wire logic                 ARST_N,
    input  wire logic                 CLK_EN,
    input  wire rrit_pkg::rrit_addr_t ADDR,
    input  wire logic                 ROM_SELECT_LINE,
    input  wire logic                 RW,
    input  wire rrit_pkg::rrit_byte_t DATA_IN,
    output logic [7:0]                DATA_OUT,
    output logic                      DATA_OE,
    input  wire rrit_pkg::rrit_byte_t PA_IN,
    output logic [7:0]                PA_OUT,
    output logic [7:0]                PA_OE,
    input  wire rrit_pkg::rrit_byte_t PB_IN,
    output logic [7:0]                PB_OUT,
    output logic [7:0]                PB_OE
);
    import rrit_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    rrit_byte_t ram_mem [`RRIT_RAM_DEPTH];
    rrit_byte_t pa_dir_q, pa_out_q, pb_dir_q, pb_out_q;
    rrit_byte_t pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q;
    rrit_byte_t cnt_q, cnt_d;
    logic [9:0] pre_q, pre_d;
    rrit_div_e  div_q, div_d;
    logic       flag_q, flag_d;
    logic       irq_en_q, irq_en_d;
    rrit_byte_t dout_q, dout_d;
    logic       doe_q;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire        sel1_pin = PB_IN[`RRIT_PB_SEL1];
    wire        sel2_pin = PB_IN[`RRIT_PB_SEL2];
    wire rrit_dec_t dec_key = {ROM_SELECT_LINE, sel1_pin, sel2_pin, ADDR[9:6]};
    // Selects masked as port bits take no part in the decode
    wire rrit_dec_t sel_keep = {1'b1, SEL1_IS_SELECT, SEL2_IS_SELECT, 4'hF};

    wire rom_hit = ((dec_key ^ ROM_MATCH) & ROM_CARE & sel_keep) == 7'h00;
    wire ram_hit = !rom_hit && ((dec_key ^ RAM_MATCH) & RAM_CARE & sel_keep) == 7'h00;
    wire io_hit  = !rom_hit && !ram_hit && ((dec_key ^ IO_MATCH) & IO_CARE & sel_keep) == 7'h00;

    wire tmr_hit  = io_hit && ADDR[`RRIT_A_TIMER];
    wire port_hit = io_hit && !ADDR[`RRIT_A_TIMER];
    wire [1:0] reg_code = ADDR[1:0];
    wire port_wr  = port_hit && !RW;
    wire tmr_wr   = tmr_hit && !RW;
    // A0 picks count or flag on reads
    wire cnt_rd   = tmr_hit && RW && !ADDR[`RRIT_A_FLAG_RD];
    wire flag_rd  = tmr_hit && RW && ADDR[`RRIT_A_FLAG_RD];
    wire any_rd   = RW && (rom_hit || ram_hit || io_hit);

    // ------------------------------------------------------------
    // ROM pattern
    // ------------------------------------------------------------
    // Stand-in for the mask pattern; swap the function body per part
    function automatic rrit_byte_t rom_byte(input rrit_addr_t a);
        rom_byte = a[7:0] ^ {6'h00, a[9:8]};
    endfunction

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    // pins for inputs, register bits for outputs
    wire rrit_byte_t pa_view = (pa_dir_q & pa_out_q) | (~pa_dir_q & pa_s2_q);
    wire rrit_byte_t pb_view = (pb_dir_q & pb_out_q) | (~pb_dir_q & pb_s2_q);
    wire rrit_byte_t flag_byte = {flag_q, 7'h00};
    wire rrit_byte_t port_byte =
        (reg_code == `RRIT_REG_PA_OUT) ? pa_view :
        (reg_code == `RRIT_REG_PA_DIR) ? pa_dir_q :
        (reg_code == `RRIT_REG_PB_OUT) ? pb_view : pb_dir_q;
    assign dout_d = rom_hit  ? rom_byte(ADDR) :
                    ram_hit  ? ram_mem[ADDR[`RRIT_RAM_AW-1:0]] :
                    port_hit ? port_byte :
                    flag_rd  ? flag_byte : cnt_q;

    // ------------------------------------------------------------
    // Timer next state
    // ------------------------------------------------------------
    wire [9:0] pre_mask = (div_q == RRIT_DIV_1)  ? `RRIT_PRE_MASK_1 :
                          (div_q == RRIT_DIV_8)  ? `RRIT_PRE_MASK_8 :
                          (div_q == RRIT_DIV_64) ? `RRIT_PRE_MASK_64 : `RRIT_PRE_MASK_1024;
    wire       tick     = (pre_q & pre_mask) == pre_mask;
    // Zero reached: the next clock is the interrupting count
    wire       fire     = !flag_q && (cnt_q == `RRIT_CNT_ZERO);

    // Countdown, flag and routing
    always_comb begin
        cnt_d    = cnt_q;
        pre_d    = pre_q + 10'h001;
        div_d    = div_q;
        flag_d   = flag_q;
        irq_en_d = irq_en_q;
        if (tmr_wr) begin
            // count from data, interval from A1A0
            cnt_d    = DATA_IN;
            div_d    = rrit_div_e'(ADDR[1:0]);
            pre_d    = `RRIT_PRE_RST;
            flag_d   = 1'b0;
            irq_en_d = ADDR[`RRIT_A_IRQ_EN];
        end else begin
            if (flag_q) begin
                // one clock rate, floor at minus 255
                if (cnt_q != `RRIT_CNT_FLOOR) begin
                    cnt_d = cnt_q - 8'h01;
                end
            end else if (fire) begin
                // wrap to all ones and flag
                cnt_d = `RRIT_CNT_WRAP;
            end else if (tick) begin
                cnt_d = cnt_q - 8'h01;
            end
            if (cnt_rd) begin
                // routing from A3 on count reads too
                irq_en_d = ADDR[`RRIT_A_IRQ_EN];
                flag_d   = 1'b0;
            end
            // setting wins over a same-cycle read
            if (fire) begin
                flag_d = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Two stages; only the second feeds read data
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pa_s1_q <= `RRIT_BYTE_RST;
            pa_s2_q <= `RRIT_BYTE_RST;
            pb_s1_q <= `RRIT_BYTE_RST;
            pb_s2_q <= `RRIT_BYTE_RST;
        end else if (CLK_EN) begin
            pa_s1_q <= PA_IN;
            pa_s2_q <= pa_s1_q;
            pb_s1_q <= PB_IN;
            pb_s2_q <= pb_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Port registers
    // ------------------------------------------------------------
    // reset clears all four
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pa_out_q <= `RRIT_BYTE_RST;
            pa_dir_q <= `RRIT_BYTE_RST;
            pb_out_q <= `RRIT_BYTE_RST;
            pb_dir_q <= `RRIT_BYTE_RST;
        end else if (CLK_EN && port_wr) begin
            if (reg_code == `RRIT_REG_PA_OUT) begin
                pa_out_q <= DATA_IN;
            end else if (reg_code == `RRIT_REG_PA_DIR) begin
                pa_dir_q <= DATA_IN;
            end else if (reg_code == `RRIT_REG_PB_OUT) begin
                pb_out_q <= DATA_IN;
            end else begin
                pb_dir_q <= DATA_IN;
            end
        end
    end

    // ------------------------------------------------------------
    // Timer registers
    // ------------------------------------------------------------
    // interrupt routing off after reset
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_q    <= `RRIT_BYTE_RST;
            pre_q    <= `RRIT_PRE_RST;
            div_q    <= RRIT_DIV_1;
            flag_q   <= 1'b0;
            irq_en_q <= 1'b0;
        end else if (CLK_EN) begin
            cnt_q    <= cnt_d;
            pre_q    <= pre_d;
            div_q    <= div_d;
            flag_q   <= flag_d;
            irq_en_q <= irq_en_d;
        end
    end

    // ------------------------------------------------------------
    // RAM array
    // ------------------------------------------------------------
    // No reset: contents are undefined at power-up, as in static RAM
    always_ff @(posedge SYS_CLK) begin
        if (CLK_EN && ram_hit && !RW) begin
            ram_mem[ADDR[`RRIT_RAM_AW-1:0]] <= DATA_IN;
        end
    end

    // ------------------------------------------------------------
    // Data bus drive
    // ------------------------------------------------------------
    // drive only the cycle after an addressed read
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dout_q <= `RRIT_BYTE_RST;
            doe_q  <= 1'b0;
        end else if (CLK_EN) begin
            dout_q <= any_rd ? dout_d : `RRIT_BYTE_RST;
            doe_q  <= any_rd;
        end
    end

    assign DATA_OUT = dout_q;
    assign DATA_OE  = doe_q;

    // ------------------------------------------------------------
    // Port pins
    // ------------------------------------------------------------
    // direction one drives register bit, except select pins and port B bit 7 while the interrupt pulls it low
    // direction zero leaves the line to its pull-up, except port B bit 7 while the interrupt pulls it low
    assign PA_OUT = pa_out_q;
    assign PA_OE  = pa_dir_q;

    wire irq_drive = flag_q && irq_en_q;
    // a select pin never drives as a port bit
    wire rrit_byte_t pb_keep = {1'b1, !SEL1_IS_SELECT, !SEL2_IS_SELECT, 5'h1F};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pb
            if (gi == `RRIT_PB_IRQ) begin : g_irq
                assign PB_OUT[gi] = irq_drive ? 1'b0 : pb_out_q[gi];
                assign PB_OE[gi]  = irq_drive || pb_dir_q[gi];
            end else begin : g_io
                assign PB_OUT[gi] = pb_out_q[gi];
                assign PB_OE[gi]  = pb_dir_q[gi] && pb_keep[gi];
            end
        end
    endgenerate

endmodule // rrit_top
`default_nettype wire

// *** logic/rrit_consts.svh ***
// Constants for the ROM, RAM, I/O and interval timer block.
// Assumes inclusion by bare name from the top module.
`ifndef RRIT_CONSTS_SVH
`define RRIT_CONSTS_SVH

// ----------------------------------------------------------------
// Memory sizes
// ----------------------------------------------------------------
`define RRIT_ROM_DEPTH   1024
`define RRIT_RAM_DEPTH   64
`define RRIT_RAM_AW      6

// ----------------------------------------------------------------
// Address bit positions inside the I/O-timer group
// ----------------------------------------------------------------
`define RRIT_A_TIMER     2
`define RRIT_A_IRQ_EN    3
`define RRIT_A_FLAG_RD   0

// ----------------------------------------------------------------
// Port register codes on A1..A0
// ----------------------------------------------------------------
`define RRIT_REG_PA_OUT  2'h0
`define RRIT_REG_PA_DIR  2'h1
`define RRIT_REG_PB_OUT  2'h2
`define RRIT_REG_PB_DIR  2'h3

// ----------------------------------------------------------------
// Timer figures
// ----------------------------------------------------------------
`define RRIT_PRE_MASK_1    10'h000
`define RRIT_PRE_MASK_8    10'h007
`define RRIT_PRE_MASK_64   10'h03F
`define RRIT_PRE_MASK_1024 10'h3FF
`define RRIT_CNT_ZERO      8'h00
`define RRIT_CNT_WRAP      8'hFF
`define RRIT_CNT_FLOOR     8'h01
`define RRIT_FLAG_BIT      7

// ----------------------------------------------------------------
// Port B bits with a second role
// ----------------------------------------------------------------
`define RRIT_PB_IRQ      7
`define RRIT_PB_SEL1     6
`define RRIT_PB_SEL2     5

// ----------------------------------------------------------------
// Reset values and default decode masks {RS,SEL1,SEL2,A9,A8,A7,A6}
// ----------------------------------------------------------------
`define RRIT_BYTE_RST    8'h00
`define RRIT_PRE_RST     10'h000
`define RRIT_ROM_CARE    7'h40
`define RRIT_ROM_MATCH   7'h40
`define RRIT_RAM_CARE    7'h4F
`define RRIT_RAM_MATCH   7'h00
`define RRIT_IO_CARE     7'h4F
`define RRIT_IO_MATCH    7'h08

`endif

// *** logic/rrit_pkg.sv ***
// Types for the ROM, RAM, I/O and interval timer block.
// Assumes the constants header sits beside it.
package rrit_pkg;
    typedef logic [7:0] rrit_byte_t;
    typedef logic [9:0] rrit_addr_t;
    typedef logic [6:0] rrit_dec_t;
    // Interval length chosen by A1..A0 on a timer write
    typedef enum logic [1:0] {
        RRIT_DIV_1,
        RRIT_DIV_8,
        RRIT_DIV_64,
        RRIT_DIV_1024
    } rrit_div_e;
endpackage

// *** verif/rrit_monitor.sv ***
// Concurrent checks on the ports of the ROM, RAM, I/O and timer block.
// Assumes default decode masks and both optional selects kept as port B bits.
`timescale 1ns/1ps
`default_nettype none
module rrit_monitor (
    input  wire logic                 SYS_CLK,
    input  wire logic                 ARST_N,
    input  wire logic                 CLK_EN,
    input  wire rrit_pkg::rrit_addr_t ADDR,
    input  wire logic                 ROM_SELECT_LINE,
    input  wire logic                 RW,
    input  wire rrit_pkg::rrit_byte_t DATA_IN,
    input  wire logic [7:0]           DATA_OUT,
    input  wire logic                 DATA_OE,
    input  wire logic [7:0]           PA_OUT,
    input  wire logic [7:0]           PA_OE,
    input  wire logic [7:0]           PB_OUT,
    input  wire logic [7:0]           PB_OE
);
    import rrit_pkg::*;
    logic io;
    logic hit;
    logic t_acc;

    // Group decode with the default masks
    assign io    = CLK_EN && !ROM_SELECT_LINE && ADDR[9:6] == 4'h8;
    assign hit   = CLK_EN && (ROM_SELECT_LINE || ADDR[9:6] == 4'h0 || ADDR[9:6] == 4'h8);
    assign t_acc = io && ADDR[2] && (!RW || !ADDR[0]);

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!ARST_N);

    // Timer load, then the steps that read it back
    sequence tmr_load;
        io && !RW && ADDR[2];
    endsequence
    sequence tmr_read;
        io && RW && ADDR[2] && !ADDR[0];
    endsequence
    sequence flag_read;
        io && RW && ADDR[2] && ADDR[0];
    endsequence

    chk_read_answer: assert property (hit && RW |=> DATA_OE)
        else $error("addressed read not driven");
    chk_bus_quiet: assert property (DATA_OE |-> $past(hit && RW))
        else $error("data bus driven without read");
    chk_pa_dir_load: assert property (io && !RW && ADDR[2:0] == 3'h1 |=> PA_OE == $past(DATA_IN))
        else $error("port A direction not loaded");
    chk_pb_out_load: assert property (io && !RW && ADDR[2:0] == 3'h2 |=> PB_OUT[6:0] == $past(DATA_IN[6:0]))
        else $error("port B output not loaded");
    chk_pa_out_hold: assert property ($changed(PA_OUT) |-> $past(io && !RW && ADDR[2:0] == 3'h0))
        else $error("port A output changed without write");
    chk_irq_pull: assert property (PB_OE[7] && !$past(PB_OE[7]) && !$past(io && !RW && ADDR[2:0] == 3'h3)
        |-> !PB_OUT[7])
        else $error("interrupt line not pulled low");
    chk_route_off: assert property (t_acc && !ADDR[3] && !PB_OE[7] |=> !PB_OE[7])
        else $error("interrupt driven with routing off");
    chk_flag_format: assert property (flag_read |=> DATA_OUT[6:0] == 7'h00)
        else $error("flag read low bits not zero");
    chk_load_read: assert property (tmr_load ##1 tmr_read |=> DATA_OUT == $past(DATA_IN, 2))
        else $error("loaded count not read back");
    chk_set_wins: assert property ((tmr_load and (DATA_IN == 8'h00 && ADDR[1:0] == 2'h0)) ##1 tmr_read
        ##1 flag_read |=> DATA_OUT[7])
        else $error("flag lost to read in set cycle");
endmodule // rrit_monitor

bind rrit_top rrit_monitor u_mon (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .CLK_EN(CLK_EN), .ADDR(ADDR),
    .ROM_SELECT_LINE(ROM_SELECT_LINE), .RW(RW), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
    .PA_OUT(PA_OUT), .PA_OE(PA_OE), .PB_OUT(PB_OUT), .PB_OE(PB_OE));
`default_nettype wire

// *** verif/rrit_cpu_model.sv ***
// Processor model driving the byte bus of the block.
// Assumes the same clock as the block; the bench calls its tasks.
`timescale 1ns/1ps
`default_nettype none
module rrit_cpu_model (
    input  wire logic                 clk,
    input  wire logic [7:0]           data_out,
    output logic                      clk_en,
    output rrit_pkg::rrit_addr_t      addr,
    output logic                      rom_select_line,
    output logic                      rw,
    output rrit_pkg::rrit_byte_t      din
);
    import rrit_pkg::*;

    initial begin
        clk_en = 1'b1;
        {rom_select_line, addr} = 11'h3C0;
        rw = 1'b1;
        din = 8'h00;
    end

    // One cycle: drive after an edge, hold through the taking edge
    task automatic cyc(input logic [10:0] a, input logic w, input rrit_byte_t d, output rrit_byte_t q);
        {rom_select_line, addr} = a;
        rw = ~w;
        // Released data lines toggle so a stale byte never looks valid
        din = w ? d : ~din;
        @(posedge clk);
        #1 q = data_out;
    endtask

    task automatic wr(input logic [10:0] a, input rrit_byte_t d);
        rrit_byte_t q;
        cyc(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [10:0] a, output rrit_byte_t q);
        cyc(a, 1'b0, 8'h00, q);
    endtask

    // Unmapped cycle: nothing addressed, nothing written; the timer keeps counting
    task automatic idle();
        rrit_byte_t q;
        cyc(11'h3C0, 1'b0, 8'h00, q);
    endtask
endmodule // rrit_cpu_model
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the ROM, RAM, I/O and timer block.
// Assumes the processor model and the bound monitor beside it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rrit_pkg::*;
    logic       clk;
    logic       arst_n;
    logic       clk_en;
    logic       rs;
    logic       rw;
    logic       d_oe;
    rrit_addr_t addr;
    rrit_byte_t din;
    rrit_byte_t pa_in;
    rrit_byte_t pb_in;
    logic [7:0] dout;
    logic [7:0] pa_out;
    logic [7:0] pa_oe;
    logic [7:0] pb_out;
    logic [7:0] pb_oe;
    logic [7:0] v;
    logic [7:0] ex;
    logic [7:0] pa_ext = 8'h3C;
    logic [7:0] pb_ext = 8'hFF;
    logic [7:0] wv [4] = '{8'hA5, 8'h0F, 8'h5A, 8'hF0};
    int         ivl [4] = '{1, 8, 64, 1024};
    int         n_errors = 0;
    int         checks = 0;
    int         i;
    int         n;

    // Pins: driven bits follow the block, the rest the far side (pa_ext; pb_ext pull-up high)
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_ext);
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_ext);

    rrit_top u_dut (.SYS_CLK(clk), .ARST_N(arst_n), .CLK_EN(clk_en), .ADDR(addr), .ROM_SELECT_LINE(rs),
        .RW(rw), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(d_oe), .PA_IN(pa_in), .PA_OUT(pa_out),
        .PA_OE(pa_oe), .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe));
    rrit_cpu_model u_cpu (.clk(clk), .data_out(dout), .clk_en(clk_en), .addr(addr),
        .rom_select_line(rs), .rw(rw), .din(din));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Bounded wait for the interrupt pull on port B bit 7
    task automatic irq_wait(output int k);
        k = 0;
        while (!(pb_oe[7] === 1'b1 && pb_out[7] === 1'b0) && k < 4000) begin
            u_cpu.idle();
            k++;
        end
        if (k >= 4000) begin
            n_errors++;
            results();
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 arst_n = 1'b1;
        chk("pa dir rst", 8'h00, pa_oe);
        // Pins reach the read path two edges after reset lets go
        repeat (2) u_cpu.idle();
        u_cpu.rd(11'h200, v);
        chk("pa pins rst", 8'h3C, v);
        $display("test reset done");
        for (i = 0; i < 4; i++)
            u_cpu.wr(11'h200 | 11'(i), wv[i]);
        chk("pa out", 8'hA5, pa_out);
        chk("pa dir", 8'h0F, pa_oe);
        chk("pb out", 8'h5A, pb_out);
        chk("pb dir", 8'hF0, pb_oe);
        repeat (2) u_cpu.idle();
        for (i = 0; i < 4; i++) begin
            u_cpu.rd(11'h200 | 11'(i), v);
            ex = i[0] ? wv[i] : (wv[i + 1] & wv[i]) | (~wv[i + 1] & (i < 2 ? pa_ext : pb_ext));
            chk("port read", ex, v);
        end
        chk("pa out kept", 8'hA5, pa_out);
        arst_n = 1'b0;
        u_cpu.idle();
        chk("pa out rst", 8'h00, pa_out);
        chk("pb dir rst", 8'h00, pb_oe);
        arst_n = 1'b1;
        $display("test ports done");
        u_cpu.wr(11'h03F, 8'h5A);
        u_cpu.wr(11'h000, 8'hC3);
        u_cpu.wr(11'h701, 8'h55);
        u_cpu.rd(11'h03F, v);
        chk("ram top", 8'h5A, v);
        chk("bus drive", 1'b1, d_oe);
        u_cpu.rd(11'h000, v);
        chk("ram base", 8'hC3, v);
        u_cpu.rd(11'h701, v);
        chk("rom byte", 8'h02, v);
        u_cpu.rd(11'h3C0, v);
        chk("bus quiet", 1'b0, d_oe);
        $display("test memory done");
        // port B bit 7 stays an input from reset
        // Routing on for each interval length; one extra clock sets the flag
        for (i = 0; i < 4; i++) begin
            u_cpu.wr(11'h20C | 11'(i), 8'h03);
            irq_wait(n);
            chk("irq delay", 16'(3 * ivl[i] + 1), 16'(n));
        end
        u_cpu.rd(11'h204, v);
        chk("count at flag", 8'hFF, v);
        chk("irq released", 1'b0, pb_oe[7]);
        u_cpu.rd(11'h205, v);
        chk("flag cleared", 8'h00, v);
        u_cpu.wr(11'h20C, 8'h01);
        irq_wait(n);
        chk("irq delay", 16'd2, 16'(n));
        repeat (27) u_cpu.idle();
        u_cpu.rd(11'h204, v);
        chk("count past flag", 8'hE4, v);
        u_cpu.wr(11'h204, 8'h00);
        u_cpu.rd(11'h204, v);
        chk("count set cycle", 8'h00, v);
        u_cpu.rd(11'h205, v);
        chk("flag kept", 8'h80, v);
        u_cpu.idle();
        $display("test timer done");
        results();
    end
endmodule // tb_top
`default_nettype wire
